//--- design/acc_consts.vh
// constants for the comparator control block
// Notes on behaviour
// - raw result is one when positive input level exceeds negative input level.
// - comparator off bit powers comparator down at any time; zero restores it.
// - bandgap select picks internal reference for positive input, else pin 0.
// - result passes a two-flop synchronizer into the output status bit.
// - flag sets when synchronized output shows the selected edge type.
// - interrupt request only while flag, enable and global enable are set.
// - flag clears when the processor takes the comparator vector.
// - writing one to the flag clears it; writing zero leaves it.
// - capture route bit feeds comparator output to timer capture front end.
// - capture route clear leaves timer capture input disconnected.
// - mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
// - select codes 000 to 101 pick pins 1 to 6; 110, 111 reserved.
// - pin digital-off bit disables its buffer; port bit reads zero.
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH

`define ACC_ADDR_CTRL_STATUS 8'h50
`define ACC_ADDR_INPUT_SELECT 8'h7d
`define ACC_ADDR_PIN_DISABLE 8'h7e
`define ACC_ADDR_EVENT_STATUS 8'h60
`define ACC_ADDR_EVENT_MASK 8'h61

`define ACC_BIT_OFF 7
`define ACC_BIT_BANDGAP 6
`define ACC_BIT_OUTPUT 5
`define ACC_BIT_FLAG 4
`define ACC_BIT_IRQ_EN 3
`define ACC_BIT_CAPTURE 2
`define ACC_BIT_MODE_HI 1
`define ACC_BIT_MODE_LO 0

`define ACC_SEL_MSB 2
`define ACC_SEL_LSB 0
`define ACC_BIT_PIN1_OFF 1
`define ACC_BIT_PIN0_OFF 0
`define ACC_BIT_EV_RISE 0
`define ACC_BIT_EV_FALL 1

`define ACC_MODE_TOGGLE 2'h0
`define ACC_MODE_RESERVED 2'h1
`define ACC_MODE_FALL 2'h2
`define ACC_MODE_RISE 2'h3

`define ACC_RESET_CTRL 8'h00
`define ACC_RESET_SELECT 3'h0
`define ACC_RESET_PIN_OFF 2'h0
`define ACC_RESET_EVENTS 2'h0

`define ACC_SYNC_STAGES 2

`endif

//--- design/acc_sync.v
// two-flop level synchronizer, parameterised width
`timescale 1ns/1ps
`default_nettype none
module acc_sync #(
    parameter WIDTH = 1
) (
    input wire core_clk,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta;

// first stage feeds only the second stage
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        meta <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else begin
        meta <= async_in;
        sync_out <= meta;
    end
end

endmodule
`default_nettype wire

//--- design/acc_edge_det.v
// edge detector with selectable event type
`timescale 1ns/1ps
`default_nettype none
`include "acc_consts.vh"
module acc_edge_det (
    input wire core_clk,
    input wire rst,
    input wire level,
    input wire [1:0] mode,
    output wire event_pulse,
    output wire rise,
    output wire fall
);

reg prev;
reg sel_event;

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        prev <= 1'b0;
    end else begin
        prev <= level;
    end
end

assign rise = level & ~prev;
assign fall = ~level & prev;

always @* begin
    sel_event = 1'b0;
    case (mode)
        `ACC_MODE_TOGGLE: sel_event = rise | fall;
        `ACC_MODE_FALL: sel_event = fall;
        `ACC_MODE_RISE: sel_event = rise;
        default: sel_event = 1'b0;
    endcase
end

assign event_pulse = sel_event;

endmodule
`default_nettype wire

//--- design/acc_top.v
// comparator control, status and register logic
`timescale 1ns/1ps
`default_nettype none
`include "acc_consts.vh"
module acc_top #(
    parameter LEVEL_W = 8,
    parameter [LEVEL_W-1:0] BANDGAP_LEVEL = 8'h80
) (
    input wire core_clk,
    input wire rst,
    // register port
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    // core side
    input wire global_irq_enable,
    input wire vector_taken,
    output reg comparator_irq_req,
    output reg sys_irq,
    // analog levels seen by the comparator model
    input wire [LEVEL_W-1:0] comparator_pin_0,
    input wire [LEVEL_W-1:0] comparator_pin_1,
    input wire [LEVEL_W-1:0] comparator_pin_2,
    input wire [LEVEL_W-1:0] comparator_pin_3,
    input wire [LEVEL_W-1:0] comparator_pin_4,
    input wire [LEVEL_W-1:0] comparator_pin_5,
    input wire [LEVEL_W-1:0] comparator_pin_6,
    // digital side of the two shared pins
    input wire pin0_digital,
    input wire pin1_digital,
    output reg pin0_port_bit,
    output reg pin1_port_bit,
    output reg pin0_digital_off,
    output reg pin1_digital_off,
    // analog control
    output reg comparator_off,
    output reg bandgap_select,
    output reg [2:0] negative_input_select,
    // timer capture front end
    output reg capture_route_enable,
    output reg capture_trigger
);

////////////////////////////////////////////////////////////////////////////
// register state

reg comparator_irq_flag;
reg comparator_irq_enable;
reg irq_mode_high;
reg irq_mode_low;
reg [1:0] event_status;
reg [1:0] event_mask;

wire comparator_output_sync;
wire [1:0] pin_digital_sync;
wire edge_event;
wire edge_rise;
wire edge_fall;

////////////////////////////////////////////////////////////////////////////
// functions

// picks the negative level; reserved codes give full scale
function [LEVEL_W-1:0] neg_level;
    input [2:0] sel;
    input [LEVEL_W-1:0] l1;
    input [LEVEL_W-1:0] l2;
    input [LEVEL_W-1:0] l3;
    input [LEVEL_W-1:0] l4;
    input [LEVEL_W-1:0] l5;
    input [LEVEL_W-1:0] l6;
    begin
        case (sel)
            3'h0: neg_level = l1;
            3'h1: neg_level = l2;
            3'h2: neg_level = l3;
            3'h3: neg_level = l4;
            3'h4: neg_level = l5;
            3'h5: neg_level = l6;
            default: neg_level = {LEVEL_W{1'b1}};
        endcase
    end
endfunction

// write-one-to-clear with set priority
function w1c_next;
    input cur;
    input set;
    input clr;
    begin
        if (set) begin
            w1c_next = 1'b1;
        end else if (clr) begin
            w1c_next = 1'b0;
        end else begin
            w1c_next = cur;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// comparator model

wire [LEVEL_W-1:0] pos_level;
wire [LEVEL_W-1:0] neg_sel_level;
wire raw_result;

assign pos_level = bandgap_select ? BANDGAP_LEVEL : comparator_pin_0;
assign neg_sel_level = neg_level(negative_input_select, comparator_pin_1,
    comparator_pin_2, comparator_pin_3, comparator_pin_4,
    comparator_pin_5, comparator_pin_6);
// unpowered comparator drives low; turning it off can look like a fall
assign raw_result = ~comparator_off & (pos_level > neg_sel_level);

////////////////////////////////////////////////////////////////////////////
// synchronizers

// comparator output is asynchronous to the core clock
acc_sync #(
    .WIDTH(1)
) u_out_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(raw_result),
    .sync_out(comparator_output_sync)
);

acc_sync #(
    .WIDTH(2)
) u_pin_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({pin1_digital, pin0_digital}),
    .sync_out(pin_digital_sync)
);

////////////////////////////////////////////////////////////////////////////
// edge detection

acc_edge_det u_edge (
    .core_clk(core_clk),
    .rst(rst),
    .level(comparator_output_sync),
    .mode({irq_mode_high, irq_mode_low}),
    .event_pulse(edge_event),
    .rise(edge_rise),
    .fall(edge_fall)
);

////////////////////////////////////////////////////////////////////////////
// register decode

wire wr_ctrl;
wire wr_select;
wire wr_pin_off;
wire wr_ev_status;
wire wr_ev_mask;

assign wr_ctrl = wr & (addr == `ACC_ADDR_CTRL_STATUS);
assign wr_select = wr & (addr == `ACC_ADDR_INPUT_SELECT);
assign wr_pin_off = wr & (addr == `ACC_ADDR_PIN_DISABLE);
assign wr_ev_status = wr & (addr == `ACC_ADDR_EVENT_STATUS);
assign wr_ev_mask = wr & (addr == `ACC_ADDR_EVENT_MASK);

wire flag_clear;
wire next_flag;
wire [1:0] ev_set;
wire [1:0] ev_clear;
wire [1:0] next_event_status;

assign flag_clear = (wr_ctrl & wdata[`ACC_BIT_FLAG]) | vector_taken;
// a new edge in the clearing cycle keeps the flag set
assign next_flag = w1c_next(comparator_irq_flag, edge_event, flag_clear);

assign ev_set = {edge_fall, edge_rise};
assign ev_clear = wr_ev_status ? wdata[1:0] : 2'h0;
assign next_event_status[`ACC_BIT_EV_RISE] = w1c_next(
    event_status[`ACC_BIT_EV_RISE], ev_set[0], ev_clear[0]);
assign next_event_status[`ACC_BIT_EV_FALL] = w1c_next(
    event_status[`ACC_BIT_EV_FALL], ev_set[1], ev_clear[1]);

////////////////////////////////////////////////////////////////////////////
// control registers

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        comparator_off <= 1'b0;
        bandgap_select <= 1'b0;
        comparator_irq_enable <= 1'b0;
        capture_route_enable <= 1'b0;
        irq_mode_high <= 1'b0;
        irq_mode_low <= 1'b0;
    end else if (wr_ctrl) begin
        // output bit is read-only and the flag is handled apart
        comparator_off <= wdata[`ACC_BIT_OFF];
        bandgap_select <= wdata[`ACC_BIT_BANDGAP];
        comparator_irq_enable <= wdata[`ACC_BIT_IRQ_EN];
        capture_route_enable <= wdata[`ACC_BIT_CAPTURE];
        irq_mode_high <= wdata[`ACC_BIT_MODE_HI];
        irq_mode_low <= wdata[`ACC_BIT_MODE_LO];
    end
end

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        negative_input_select <= `ACC_RESET_SELECT;
    end else if (wr_select) begin
        // reserved upper bits dropped
        negative_input_select <= wdata[`ACC_SEL_MSB:`ACC_SEL_LSB];
    end
end

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        pin0_digital_off <= 1'b0;
        pin1_digital_off <= 1'b0;
    end else if (wr_pin_off) begin
        pin0_digital_off <= wdata[`ACC_BIT_PIN0_OFF];
        pin1_digital_off <= wdata[`ACC_BIT_PIN1_OFF];
    end
end

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        event_mask <= `ACC_RESET_EVENTS;
    end else if (wr_ev_mask) begin
        event_mask <= wdata[1:0];
    end
end

////////////////////////////////////////////////////////////////////////////
// flags and interrupts

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        comparator_irq_flag <= 1'b0;
        event_status <= `ACC_RESET_EVENTS;
    end else begin
        comparator_irq_flag <= next_flag;
        event_status <= next_event_status;
    end
end

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        comparator_irq_req <= 1'b0;
        sys_irq <= 1'b0;
    end else begin
        // request drops in the same edge the vector clears the flag
        comparator_irq_req <= next_flag & comparator_irq_enable &
            global_irq_enable;
        sys_irq <= |(next_event_status & event_mask);
    end
end

////////////////////////////////////////////////////////////////////////////
// timer capture route and pin read-back

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        capture_trigger <= 1'b0;
    end else begin
        // held low when not routed so the timer sees no edges
        capture_trigger <= capture_route_enable &
            comparator_output_sync;
    end
end

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        pin0_port_bit <= 1'b0;
        pin1_port_bit <= 1'b0;
    end else begin
        pin0_port_bit <= pin_digital_sync[0] & ~pin0_digital_off;
        pin1_port_bit <= pin_digital_sync[1] & ~pin1_digital_off;
    end
end

////////////////////////////////////////////////////////////////////////////
// read path

reg [7:0] next_rdata;

always @* begin
    next_rdata = 8'h00;
    case (addr)
        `ACC_ADDR_CTRL_STATUS: begin
            next_rdata[`ACC_BIT_OFF] = comparator_off;
            next_rdata[`ACC_BIT_BANDGAP] = bandgap_select;
            next_rdata[`ACC_BIT_OUTPUT] = comparator_output_sync;
            next_rdata[`ACC_BIT_FLAG] = comparator_irq_flag;
            next_rdata[`ACC_BIT_IRQ_EN] = comparator_irq_enable;
            next_rdata[`ACC_BIT_CAPTURE] = capture_route_enable;
            next_rdata[`ACC_BIT_MODE_HI] = irq_mode_high;
            next_rdata[`ACC_BIT_MODE_LO] = irq_mode_low;
        end
        `ACC_ADDR_INPUT_SELECT: begin
            next_rdata[`ACC_SEL_MSB:`ACC_SEL_LSB] = negative_input_select;
        end
        `ACC_ADDR_PIN_DISABLE: begin
            next_rdata[`ACC_BIT_PIN0_OFF] = pin0_digital_off;
            next_rdata[`ACC_BIT_PIN1_OFF] = pin1_digital_off;
        end
        `ACC_ADDR_EVENT_STATUS: begin
            next_rdata[1:0] = event_status;
        end
        `ACC_ADDR_EVENT_MASK: begin
            next_rdata[1:0] = event_mask;
        end
        default: begin
            next_rdata = 8'h00;
        end
    endcase
end

// unmapped addresses read zero; data only in the cycle after the strobe
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        rdata <= 8'h00;
    end else if (rd) begin
        rdata <= next_rdata;
    end else begin
        rdata <= 8'h00;
    end
end

endmodule
`default_nettype wire

//--- tb/acc_top_chk.sv
// port assertions for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module acc_top_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic global_irq_enable,
    input wire logic comparator_irq_req,
    input wire logic pin0_port_bit,
    input wire logic pin0_digital_off,
    input wire logic comparator_off,
    input wire logic bandgap_select,
    input wire logic [2:0] negative_input_select,
    input wire logic capture_route_enable,
    input wire logic capture_trigger
);
default clocking @(posedge core_clk); endclocking
default disable iff (rst);
////////////////////////////////////////
a_unmapped_read: assert property (
    rd && !(addr inside {8'h50, 8'h7d, 8'h7e, 8'h60, 8'h61})
    |=> rdata == 8'h00) else $error("unmapped read not zero");
a_ctrl_write: assert property (
    wr && addr == 8'h50 |=> {comparator_off, bandgap_select,
    capture_route_enable} == {$past(wdata[7]), $past(wdata[6]),
    $past(wdata[2])}) else $error("control bits not written");
a_sel_write: assert property (
    wr && addr == 8'h7d |=> negative_input_select == $past(wdata[2:0]))
    else $error("select field not written");
a_sel_hold: assert property (
    !(wr && addr == 8'h7d) |=> $stable(negative_input_select))
    else $error("select field changed without write");
a_pin_gate: assert property (
    pin0_digital_off && $past(pin0_digital_off) |-> !pin0_port_bit)
    else $error("port bit high while buffer off");
a_capture_off: assert property (
    !capture_route_enable && !$past(capture_route_enable)
    |-> !capture_trigger) else $error("capture fed while unrouted");
a_irq_global: assert property (
    comparator_irq_req |-> $past(global_irq_enable))
    else $error("irq request without global enable");
a_off_quiet: assert property (
    comparator_off [*4] |-> !capture_trigger)
    else $error("output active while powered off");
c_ctrl_write: cover property (wr && addr == 8'h50);
c_irq: cover property ($rose(comparator_irq_req));
c_capture: cover property ($rose(capture_trigger));
endmodule
bind acc_top acc_top_chk acc_top_chk_inst (.*);
`default_nettype wire

//--- tb/acc_top_tb.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module acc_top_tb;
logic core_clk;
logic rst = 1'b1;
logic wr = 1'b0;
logic rd = 1'b0;
logic global_irq_enable = 1'b0;
logic vector_taken = 1'b0;
logic pin0_digital = 1'b0;
logic pin1_digital = 1'b0;
logic [7:0] addr = 8'h00;
logic [7:0] wdata = 8'h00;
logic [7:0] pv [7] = '{default: 8'h00};
logic [7:0] rdata;
logic comparator_irq_req, sys_irq, pin0_port_bit, pin1_port_bit;
logic pin0_digital_off, pin1_digital_off, comparator_off;
logic bandgap_select, capture_route_enable, capture_trigger;
logic [2:0] negative_input_select;
int num_errors = 0;
int n_checks = 0;
acc_top acc_top_inst (.comparator_pin_0(pv[0]), .comparator_pin_1(pv[1]),
    .comparator_pin_2(pv[2]), .comparator_pin_3(pv[3]),
    .comparator_pin_4(pv[4]), .comparator_pin_5(pv[5]),
    .comparator_pin_6(pv[6]), .*);
////////////////////////////////////////
task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
        num_errors++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
endtask
task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
endtask
task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
endtask
// read data stands only in the cycle after the strobe
task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
endtask
task automatic summarize;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
////////////////////////////////////////
task automatic t_regs;
    rchk(8'h50, 8'h00);
    rchk(8'h7d, 8'h00);
    wreg(8'h7d, 8'hff);
    rchk(8'h7d, 8'h07);
    wreg(8'h7e, 8'hff);
    rchk(8'h7e, 8'h03);
    wreg(8'h50, 8'hff);
    rchk(8'h50, 8'hcf);
    rchk(8'h33, 8'h00);
    wreg(8'h7e, 8'h00);
    $display("t_regs done");
endtask
// mode 01 keeps the flag quiet while the inputs move
task automatic t_mux;
    wreg(8'h50, 8'h11);
    for (int i = 0; i < 8; i++) begin
        wreg(8'h7d, 8'(i));
        @(posedge core_clk);
        pv[0] <= 8'h18;
        for (int j = 1; j < 7; j++)
            pv[j] <= (j == i + 1) ? 8'h10 : 8'h20;
        cyc(3);
        rchk(8'h50, (i < 6) ? 8'h21 : 8'h01);
    end
    wreg(8'h7d, 8'h00);
    wreg(8'h50, 8'h41);
    cyc(3);
    rchk(8'h50, 8'h61);
    @(posedge core_clk);
    pv[1] <= 8'h90;
    cyc(3);
    rchk(8'h50, 8'h41);
    wreg(8'h50, 8'h01);
    @(posedge core_clk);
    pv[0] <= 8'h10;
    pv[1] <= 8'h20;
    $display("t_mux done");
endtask
task automatic t_modes;
    logic [1:0] m;
    logic er;
    logic ef;
    wreg(8'h60, 8'h03);
    wreg(8'h61, 8'h01);
    @(posedge core_clk);
    global_irq_enable <= 1'b1;
    for (int k = 0; k < 4; k++) begin
        m = 2'(k);
        er = (m == 2'h0 || m == 2'h3);
        ef = (m == 2'h0 || m == 2'h2);
        wreg(8'h50, {6'h06, m});
        @(posedge core_clk);
        pv[0] <= 8'h30;
        cyc(4);
        rchk(8'h50, {2'h0, 1'b1, er, 2'h2, m});
        chk(comparator_irq_req, er);
        wreg(8'h50, {6'h02, m});
        rchk(8'h50, {2'h0, 1'b1, er, 2'h2, m});
        wreg(8'h50, {6'h06, m});
        cyc(1);
        chk(comparator_irq_req, 1'b0);
        @(posedge core_clk);
        pv[0] <= 8'h10;
        cyc(4);
        rchk(8'h50, {3'h0, ef, 2'h2, m});
        if (m == 2'h2) begin
            global_irq_enable <= 1'b0;
            cyc(2);
            chk(comparator_irq_req, 1'b0);
            global_irq_enable <= 1'b1;
            cyc(2);
            chk(comparator_irq_req, 1'b1);
            vector_taken <= 1'b1;
            @(posedge core_clk);
            vector_taken <= 1'b0;
            cyc(1);
            chk(comparator_irq_req, 1'b0);
            rchk(8'h50, 8'h0a);
        end
        wreg(8'h50, 8'h11);
    end
    rchk(8'h60, 8'h03);
    chk(sys_irq, 1'b1);
    wreg(8'h61, 8'h00);
    // old mask still counts at the writing edge
    cyc(1);
    #1 chk(sys_irq, 1'b0);
    wreg(8'h61, 8'h01);
    wreg(8'h60, 8'h03);
    cyc(1);
    #1 chk(sys_irq, 1'b0);
    global_irq_enable <= 1'b0;
    $display("t_modes done");
endtask
task automatic t_cap;
    wreg(8'h50, 8'h05);
    @(posedge core_clk);
    pv[0] <= 8'h30;
    cyc(2);
    #1 chk(capture_trigger, 1'b0);
    cyc(1);
    #1 chk(capture_trigger, 1'b1);
    wreg(8'h50, 8'h01);
    cyc(1);
    #1 chk(capture_trigger, 1'b0);
    // route kept on so only power-down can silence the trigger
    wreg(8'h50, 8'h85);
    cyc(3);
    rchk(8'h50, 8'h85);
    chk(capture_trigger, 1'b0);
    wreg(8'h50, 8'h01);
    cyc(3);
    rchk(8'h50, 8'h21);
    $display("t_cap done");
endtask
// port bits lag the pins by the synchronizer plus one flop
task automatic t_pins;
    @(posedge core_clk);
    pin0_digital <= 1'b1;
    pin1_digital <= 1'b1;
    cyc(4);
    #1 chk({pin1_digital_off, pin0_digital_off, pin1_port_bit,
        pin0_port_bit}, 8'h03);
    wreg(8'h7e, 8'h01);
    cyc(2);
    #1 chk({pin1_digital_off, pin0_digital_off, pin1_port_bit,
        pin0_port_bit}, 8'h06);
    wreg(8'h7e, 8'h02);
    cyc(2);
    #1 chk({pin1_digital_off, pin0_digital_off, pin1_port_bit,
        pin0_port_bit}, 8'h09);
    $display("t_pins done");
endtask
////////////////////////////////////////
initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
end
initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_mux;
    t_modes;
    t_cap;
    t_pins;
    summarize;
end
// whole run is well under a few thousand cycles
initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    summarize;
end
endmodule
`default_nettype wire
